// File: uhpp_host_model.sv
`timescale 1ns/1ps
module uhpp_host_model (
   input wire logic ref_clk_i,
   input wire logic [7:0] dev_data_i,
   input wire logic dev_oe_i,
   output logic cs_n_o,
   output logic wr_n_o,
   output logic rd_n_o,
   output logic [2:0] addr_o,
   output logic [7:0] pin_data_o
);
   logic drv_r = 1'b0;
   logic [7:0] wd_r = 8'h00;
   // wire level, released line shows the inverse
   assign pin_data_o = dev_oe_i ? dev_data_i : (drv_r ? wd_r : ~wd_r);
   initial begin
      cs_n_o = 1'b1;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      addr_o = 3'h0;
   end
   // one whole bus cycle, strobes return high after
   task cycle(input logic sel_n, input logic wr, input logic [2:0] a, input logic [7:0] d,
              output logic [7:0] q, output logic got);
      got = 1'b0;
      q = 8'h00;
      @(posedge ref_clk_i);
      cs_n_o <= sel_n;
      addr_o <= a;
      wd_r <= d;
      drv_r <= wr;
      repeat (5) @(posedge ref_clk_i);
      if (wr) wr_n_o <= 1'b0;
      else rd_n_o <= 1'b0;
      for (int i = 0; i < 12 && !got; i++) begin
         @(posedge ref_clk_i);
         if (!wr && dev_oe_i === 1'b1) begin
            got = 1'b1;
            q = dev_data_i;
         end
      end
      wr_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      cs_n_o <= 1'b1;
      drv_r <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask : cycle
endmodule : uhpp_host_model

// File: uhpp_host_parallel_port_tb.sv
`timescale 1ns/1ps
module uhpp_host_parallel_port_tb;
   logic ref_clk_i = 1'b0, rstn_i = 1'b0, par = 1'b0, hs = 1'b0, rxv = 1'b0, tkn = 1'b0;
   logic [7:0] rxd = 8'h00, hdo, txd, lcr, fcr, pin, q, v;
   logic [3:0] rxe = 4'h0, ms = 4'h0;
   logic hoe, irq, vrn, offh, txv, cs_n, wr_n, rd_n, ok;
   logic [7:0] tx_byte = 8'h00;
   logic [4:0] mcr;
   logic [15:0] div;
   logic [2:0] a;
   logic [31:0] rnd = 32'h00011BCB;
   int err_total = 0, n_checks = 0, cyc = 0, tx_cnt = 0, tx_base = 0;
   int bits[4] = '{uhpp_pkg::IER_RX_BIT, uhpp_pkg::IER_THRE_BIT, uhpp_pkg::IER_LINE_BIT, uhpp_pkg::IER_MODEM_BIT};
   logic [3:0] codes[4] = '{uhpp_pkg::IIR_RX, uhpp_pkg::IIR_THRE, uhpp_pkg::IIR_LINE, uhpp_pkg::IIR_MODEM};
   logic [2:0] svc[4] = '{uhpp_pkg::ADDR_DATA, uhpp_pkg::ADDR_IIR_FCR, uhpp_pkg::ADDR_LSR, uhpp_pkg::ADDR_MSR};
   uhpp_host_port u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .parallel_interface_select_i(par),
      .host_chip_select_n_i(cs_n), .host_write_strobe_n_i(wr_n), .host_read_strobe_n_i(rd_n),
      .host_register_address_i(a), .host_data_bus_i(pin), .host_data_bus_o(hdo), .host_data_bus_oe_o(hoe),
      .host_interrupt_out_o(irq), .voice_relay_n_o(vrn), .handset_current_sense_i(hs),
      .handset_off_hook_o(offh), .rx_data_i(rxd), .rx_valid_i(rxv), .rx_error_i(rxe), .tx_data_o(txd),
      .tx_valid_o(txv), .tx_taken_i(tkn), .modem_status_i(ms), .line_ctrl_o(lcr), .modem_ctrl_o(mcr),
      .divisor_o(div), .fifo_ctrl_o(fcr));
   uhpp_host_model u_host (.ref_clk_i(ref_clk_i), .dev_data_i(hdo), .dev_oe_i(hoe), .cs_n_o(cs_n),
      .wr_n_o(wr_n), .rd_n_o(rd_n), .addr_o(a), .pin_data_o(pin));
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   function automatic logic [7:0] lsr_byte(input logic [3:0] e, input logic thre, input logic dr);
      return {|e, thre, thre, e, dr};
   endfunction : lsr_byte
   task complete_run;
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [2:0] ad, input logic [7:0] d, input logic sel_n = 1'b0);
      u_host.cycle(sel_n, 1'b1, ad, d, q, ok);
   endtask : wr
   task rd(input logic [2:0] ad, input logic sel_n = 1'b0);
      u_host.cycle(sel_n, 1'b0, ad, 8'h00, q, ok);
   endtask : rd
   always @(posedge ref_clk_i) begin
      if (txv === 1'b1) begin
         tx_cnt <= tx_cnt + 1;
         tx_byte <= txd;
      end
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      chk(hoe, 1'b0);
      chk(irq, 1'b0);
      chk(vrn, 1'b1);
      rstn_i <= 1'b1;
      par <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      for (int i = 0; i < 4; i++) begin
         rnd = nxt(rnd);
         v = rnd[7:0];
         wr(uhpp_pkg::ADDR_SCR, v);
         rd(uhpp_pkg::ADDR_SCR);
         chk(q, v);
      end
      wr(uhpp_pkg::ADDR_LCR, v & 8'h7F);
      chk(lcr, v & 8'h7F);
      wr(uhpp_pkg::ADDR_IIR_FCR, ~v);
      chk(fcr, {~v});
      wr(uhpp_pkg::ADDR_MCR, 8'h04);
      chk(vrn, 1'b0);
      chk(mcr, 5'h04);
      wr(uhpp_pkg::ADDR_MCR, 8'h00);
      chk(vrn, 1'b1);
      wr(uhpp_pkg::ADDR_LCR, 8'h80);
      wr(uhpp_pkg::ADDR_DATA, v);
      wr(uhpp_pkg::ADDR_IER, ~v);
      chk(div, {~v, v});
      wr(uhpp_pkg::ADDR_LCR, 8'h00);
      tx_base = tx_cnt;
      wr(uhpp_pkg::ADDR_DATA, ~v);
      chk(16'(tx_cnt - tx_base), 16'h0001);
      chk(tx_byte, {~v});
      wr(uhpp_pkg::ADDR_SCR, 8'hC3);
      wr(uhpp_pkg::ADDR_SCR, 8'h3C, 1'b1);
      rd(uhpp_pkg::ADDR_SCR, 1'b1);
      chk({ok, hoe}, 2'h0);
      par <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      wr(uhpp_pkg::ADDR_SCR, 8'h96);
      rd(uhpp_pkg::ADDR_SCR);
      chk(ok, 1'b0);
      par <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      rd(uhpp_pkg::ADDR_SCR);
      chk(q, 8'hC3);
      for (int k = 0; k < 4; k++) begin
         rnd = nxt(rnd);
         wr(uhpp_pkg::ADDR_IER, 8'(1 << bits[k]));
         @(posedge ref_clk_i);
         case (k)
            0: begin
               rxd <= rnd[7:0];
               rxv <= 1'b1;
            end
            1: tkn <= 1'b1;
            2: rxe <= 4'h1;
            default: ms <= ~ms;
         endcase
         @(posedge ref_clk_i);
         rxv <= 1'b0;
         tkn <= 1'b0;
         rxe <= 4'h0;
         repeat (4) @(posedge ref_clk_i);
         chk(irq, 1'b1);
         rd(uhpp_pkg::ADDR_IIR_FCR);
         chk(q[3:0], codes[k]);
         rd(svc[k]);
         case (k)
            0: chk(q, rnd[7:0]);
            1: chk(q[3:0], uhpp_pkg::IIR_NONE);
            2: chk(q, lsr_byte(4'h1, 1'b1, 1'b0));
            default: chk(q, {ms, 4'hF});
         endcase
         repeat (4) @(posedge ref_clk_i);
         chk(irq, 1'b0);
      end
      ms <= ~ms;
      repeat (4) @(posedge ref_clk_i);
      chk(irq, 1'b1);
      rstn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk(irq, 1'b0);
      chk(hoe, 1'b0);
      rstn_i <= 1'b1;
      hs <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      chk(offh, 1'b1);
      hs <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      chk(offh, 1'b0);
      complete_run();
   end
endmodule : uhpp_host_parallel_port_tb

// File: uhpp_host_port.sv
`timescale 1ns/1ps
module uhpp_host_port (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic parallel_interface_select_i,
   input wire logic host_chip_select_n_i,
   input wire logic host_write_strobe_n_i,
   input wire logic host_read_strobe_n_i,
   input wire logic [2:0] host_register_address_i,
   input wire logic [7:0] host_data_bus_i,
   output logic [7:0] host_data_bus_o,
   output logic host_data_bus_oe_o,
   output logic host_interrupt_out_o,
   output logic voice_relay_n_o,
   input wire logic handset_current_sense_i,
   output logic handset_off_hook_o,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic [3:0] rx_error_i,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_taken_i,
   input wire logic [3:0] modem_status_i,
   output logic [7:0] line_ctrl_o,
   output logic [4:0] modem_ctrl_o,
   output logic [15:0] divisor_o,
   output logic [7:0] fifo_ctrl_o
);
   uhpp_pkg::uhpp_pins_s pins_raw;
   uhpp_pkg::uhpp_pins_s pins;
   logic sel;
   logic wr_act;
   logic rd_act;
   logic wr_act_r;
   logic rd_act_r;
   logic wr_start;
   logic rd_start;
   logic dlab;
   logic [3:0] ier_r;
   logic [7:0] lcr_r;
   logic [4:0] mcr_r;
   logic [7:0] dll_r;
   logic [7:0] dlm_r;
   logic [7:0] scr_r;
   logic [7:0] fcr_r;
   logic [7:0] rbr_r;
   logic dr_r;
   logic [3:0] err_r;
   logic thre_r;
   logic thri_r;
   logic [3:0] msr_prev_r;
   logic [3:0] msr_delta_r;
   logic [3:0] pend;
   logic [3:0] iir_code;
   logic [7:0] rd_val;
   logic [7:0] rdata_r;
   logic int_r;
   logic wr_thr;
   logic rd_rbr;
   logic rd_iir;
   logic rd_lsr;
   logic rd_msr;

   assign pins_raw = '{par: parallel_interface_select_i, handset: handset_current_sense_i,
                       cs_n: host_chip_select_n_i, wr_n: host_write_strobe_n_i,
                       rd_n: host_read_strobe_n_i, addr: host_register_address_i,
                       data: host_data_bus_i};

   uhpp_sync3 #(
      .WIDTH($bits(uhpp_pkg::uhpp_pins_s)),
      .RESET_VAL(uhpp_pkg::PINS_IDLE)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i(pins_raw),
      .level_o(pins)
   );

   // bus cycle qualification
   assign sel = pins.par & ~pins.cs_n;
   assign wr_act = sel & ~pins.wr_n;
   assign rd_act = sel & ~pins.rd_n & pins.wr_n;
   assign wr_start = wr_act & ~wr_act_r;
   assign rd_start = rd_act & ~rd_act_r;
   assign dlab = lcr_r[uhpp_pkg::LCR_DLAB_BIT];

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
      end else begin
         wr_act_r <= wr_act;
         rd_act_r <= rd_act;
      end
   end

   // address decode of side-effect accesses
   assign wr_thr = wr_start && pins.addr == uhpp_pkg::ADDR_DATA && !dlab;
   assign rd_rbr = rd_start && pins.addr == uhpp_pkg::ADDR_DATA && !dlab;
   assign rd_iir = rd_start && pins.addr == uhpp_pkg::ADDR_IIR_FCR;
   assign rd_lsr = rd_start && pins.addr == uhpp_pkg::ADDR_LSR;
   assign rd_msr = rd_start && pins.addr == uhpp_pkg::ADDR_MSR;

   // host writes into control registers
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ier_r <= uhpp_pkg::IER_RESET;
         lcr_r <= uhpp_pkg::LCR_RESET;
         mcr_r <= uhpp_pkg::MCR_RESET;
         dll_r <= uhpp_pkg::BYTE_RESET;
         dlm_r <= uhpp_pkg::BYTE_RESET;
         scr_r <= uhpp_pkg::BYTE_RESET;
         fcr_r <= uhpp_pkg::BYTE_RESET;
      end else if (wr_start) begin
         case (pins.addr)
            uhpp_pkg::ADDR_DATA: if (dlab) dll_r <= pins.data;
            uhpp_pkg::ADDR_IER: begin
               if (dlab) dlm_r <= pins.data;
               else ier_r <= pins.data[3:0];
            end
            uhpp_pkg::ADDR_IIR_FCR: fcr_r <= pins.data;
            uhpp_pkg::ADDR_LCR: lcr_r <= pins.data;
            uhpp_pkg::ADDR_MCR: mcr_r <= pins.data[4:0];
            uhpp_pkg::ADDR_SCR: scr_r <= pins.data;
            default: ;
         endcase
      end
   end

   // transmit holding register handoff
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         tx_data_o <= uhpp_pkg::BYTE_RESET;
         tx_valid_o <= 1'b0;
         thre_r <= 1'b1;
         thri_r <= 1'b0;
      end else begin
         tx_valid_o <= wr_thr;
         if (wr_thr) tx_data_o <= pins.data;
         thre_r <= tx_taken_i | (thre_r & ~wr_thr);
         thri_r <= tx_taken_i | (thri_r & ~wr_thr & ~(rd_iir && iir_code == uhpp_pkg::IIR_THRE));
      end
   end

   // receive data and line errors, set wins over clear
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rbr_r <= uhpp_pkg::BYTE_RESET;
         dr_r <= 1'b0;
         err_r <= uhpp_pkg::NIB_RESET;
      end else begin
         if (rx_valid_i) rbr_r <= rx_data_i;
         dr_r <= rx_valid_i | (dr_r & ~rd_rbr);
         err_r <= rx_error_i | {3'h0, rx_valid_i & dr_r} | (err_r & {4{~rd_lsr}});
      end
   end

   // modem status change tracking
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         msr_prev_r <= uhpp_pkg::NIB_RESET;
         msr_delta_r <= uhpp_pkg::NIB_RESET;
      end else begin
         msr_prev_r <= modem_status_i;
         msr_delta_r <= (modem_status_i ^ msr_prev_r) | (msr_delta_r & {4{~rd_msr}});
      end
   end

   // interrupt sources, priority and output
   assign pend[uhpp_pkg::IER_RX_BIT] = dr_r & ier_r[uhpp_pkg::IER_RX_BIT];
   assign pend[uhpp_pkg::IER_THRE_BIT] = thri_r & ier_r[uhpp_pkg::IER_THRE_BIT];
   assign pend[uhpp_pkg::IER_LINE_BIT] = (|err_r) & ier_r[uhpp_pkg::IER_LINE_BIT];
   assign pend[uhpp_pkg::IER_MODEM_BIT] = (|msr_delta_r) & ier_r[uhpp_pkg::IER_MODEM_BIT];

   always_comb begin
      if (pend[uhpp_pkg::IER_LINE_BIT]) iir_code = uhpp_pkg::IIR_LINE;
      else if (pend[uhpp_pkg::IER_RX_BIT]) iir_code = uhpp_pkg::IIR_RX;
      else if (pend[uhpp_pkg::IER_THRE_BIT]) iir_code = uhpp_pkg::IIR_THRE;
      else if (pend[uhpp_pkg::IER_MODEM_BIT]) iir_code = uhpp_pkg::IIR_MODEM;
      else iir_code = uhpp_pkg::IIR_NONE;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) int_r <= 1'b0;
      else int_r <= pins.par & (|pend);
   end

   // read mux and data bus drive
   always_comb begin
      case (pins.addr)
         uhpp_pkg::ADDR_DATA: rd_val = dlab ? dll_r : rbr_r;
         uhpp_pkg::ADDR_IER: rd_val = dlab ? dlm_r : {4'h0, ier_r};
         uhpp_pkg::ADDR_IIR_FCR: rd_val = {4'h0, iir_code};
         uhpp_pkg::ADDR_LCR: rd_val = lcr_r;
         uhpp_pkg::ADDR_MCR: rd_val = {3'h0, mcr_r};
         uhpp_pkg::ADDR_LSR: rd_val = {|err_r, thre_r, thre_r, err_r, dr_r};
         uhpp_pkg::ADDR_MSR: rd_val = {modem_status_i, msr_delta_r};
         uhpp_pkg::ADDR_SCR: rd_val = scr_r;
         default: rd_val = uhpp_pkg::BYTE_RESET;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) rdata_r <= uhpp_pkg::BYTE_RESET;
      else if (rd_start) rdata_r <= rd_val;
   end

   assign host_data_bus_o = rdata_r;
   assign host_data_bus_oe_o = rd_act_r & rd_act;
   assign host_interrupt_out_o = int_r;
   assign voice_relay_n_o = ~mcr_r[uhpp_pkg::MCR_VOICE_BIT];
   assign handset_off_hook_o = pins.handset;
   assign line_ctrl_o = lcr_r;
   assign modem_ctrl_o = mcr_r;
   assign divisor_o = {dlm_r, dll_r};
   assign fifo_ctrl_o = fcr_r;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_read_start;
      rd_start ##1 rd_act;
   endsequence

   a_bus_hiz_deselect: assert property (pins.cs_n |-> !host_data_bus_oe_o)
      else $error("data bus driven while deselected");
   a_strap_off_quiet: assert property (!pins.par |=> !host_interrupt_out_o && !host_data_bus_oe_o)
      else $error("port active with strap low");
   a_read_drives_data: assert property (s_read_start |-> host_data_bus_oe_o
                                        && host_data_bus_o == $past(rd_val))
      else $error("read data not driven");
   a_write_thr_tx: assert property (wr_thr |=> tx_valid_o && tx_data_o == $past(pins.data))
      else $error("holding register write lost");
   a_int_on_rx: assert property (rx_valid_i && ier_r[uhpp_pkg::IER_RX_BIT] && pins.par && $stable(pins.par)
                                 |-> ##2 host_interrupt_out_o)
      else $error("rx interrupt missing");
   a_rx_flag_clear: assert property (rd_rbr && !rx_valid_i |=> !dr_r)
      else $error("rx flag not cleared by data read");
   a_voice_relay_on: assert property (wr_start && pins.addr == uhpp_pkg::ADDR_MCR
                                      && pins.data[uhpp_pkg::MCR_VOICE_BIT] |=> !voice_relay_n_o)
      else $error("voice relay not energised");
   a_handset_follow: assert property (handset_current_sense_i [*6] |-> handset_off_hook_o)
      else $error("handset off hook not seen");
   a_no_write_deselect: assert property (pins.cs_n |-> !wr_start)
      else $error("write taken while deselected");
endmodule : uhpp_host_port

// File: uhpp_pkg.sv
package uhpp_pkg;

   // register indices on the three address lines
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_IIR_FCR = 3'h2;
   localparam logic [2:0] ADDR_LCR = 3'h3;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_LSR = 3'h5;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   localparam logic [2:0] ADDR_SCR = 3'h7;

   // field positions
   localparam int LCR_DLAB_BIT = 7;
   localparam int MCR_VOICE_BIT = 2;
   localparam int IER_RX_BIT = 0;
   localparam int IER_THRE_BIT = 1;
   localparam int IER_LINE_BIT = 2;
   localparam int IER_MODEM_BIT = 3;

   // interrupt identification codes
   localparam logic [3:0] IIR_NONE = 4'h1;
   localparam logic [3:0] IIR_LINE = 4'h6;
   localparam logic [3:0] IIR_RX = 4'h4;
   localparam logic [3:0] IIR_THRE = 4'h2;
   localparam logic [3:0] IIR_MODEM = 4'h0;

   // reset values
   localparam logic [3:0] IER_RESET = 4'h0;
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam logic [4:0] MCR_RESET = 5'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] NIB_RESET = 4'h0;

   // host pins as one bundle through the synchroniser
   typedef struct packed {
      logic par;
      logic handset;
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic [2:0] addr;
      logic [7:0] data;
   } uhpp_pins_s;

   localparam uhpp_pins_s PINS_IDLE = '{par: 1'b0, handset: 1'b0, cs_n: 1'b1, wr_n: 1'b1,
                                       rd_n: 1'b1, addr: 3'h0, data: 8'h00};

endpackage : uhpp_pkg

// File: uhpp_sync3.sv
`timescale 1ns/1ps
module uhpp_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // level changes only once stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
         level_o <= RESET_VAL;
      end else begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_o <= (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & level_o);
      end
   end
endmodule : uhpp_sync3
